/* src/spp_cfg.svh */
// Constants for the stream put port: instruction fields, codes, latencies
// Assumes a little-endian bit numbering of the instruction word (bit 0 = LSB)
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH
`define SPP_NUM_LINKS       16
`define SPP_LINK_W          4
`define SPP_DATA_W          32
`define SPP_OPC_HI          31
`define SPP_OPC_LO          26
`define SPP_OPC_PUT         6'h1b
`define SPP_PUT_SEL_BIT     15
`define SPP_MOD_N_BIT       14
`define SPP_MOD_C_BIT       13
`define SPP_MOD_T_BIT       12
`define SPP_MOD_A_BIT       11
`define SPP_RA_HI           20
`define SPP_RA_LO           16
`define SPP_LINK_HI         3
`define SPP_LINK_LO         0
`define SPP_EC_PRIV         5'h07
`define SPP_LAT_FAST        2'h1
`define SPP_LAT_AREA        2'h2
`endif

/* src/spp_pkg.sv */
// Types shared by the stream put port
// Assumes spp_cfg.svh sits on the include path
package spp_pkg;
	typedef enum logic [1:0] {
		SPP_IDLE,
		SPP_WAIT,
		SPP_BUSY
	} spp_state_e;
endpackage : spp_pkg

/* src/spp_link_sel.sv */
// Link index range check for the stream put port; out of range selects link 0
// Assumes a combinational use inside the put port
`timescale 1ns/1ps
`include "spp_cfg.svh"
module spp_link_sel #(
	parameter int LINK_COUNT = 16
) (
	// Requested link
	input  wire logic [`SPP_LINK_W-1:0] linkIndexField,
	// Resolved link
	output logic      [`SPP_LINK_W-1:0] linkSel
);
	always_comb begin
		if ({1'b0, linkIndexField} >= 5'(LINK_COUNT)) begin
			linkSel = '0;
		end else begin
			linkSel = linkIndexField;
		end
	end
endmodule : spp_link_sel

/* src/spp_put_port.sv */
// Summary of operation
// - Link index from instruction bits 0-3; out of range uses link 0.
// - Source register contents drive the selected link's TDATA.
// - Blocking put stalls until the link accepts the word.
// - Non-blocking put never stalls; carry 0 if space, 1 if none.
// - TLAST low for data puts, high for control puts.
// - Test puts act normally but never assert TVALID.
// - Atomic puts block interrupts up to the next non-put instruction or the end of the next non-atomic put.
// - With memory management level nonzero, user mode without permission raises privilege exception, cause 00111.
// - Unstalled put takes 1 cycle, or 2 at area tuning level 1.
// - Stalled blocking put lets interrupts in if extended, not atomic and not following an atomic put.
// - Puts exist only when the link count exceeds zero.
// - Test and atomic forms exist only with extended ops enabled.
// - Four modifier bits decode into 16 distinct variants.
//
// Stream put execution unit facing sixteen outgoing stream links
// Assumes the pipeline holds instrValid and operands until putDone
`timescale 1ns/1ps
`include "spp_cfg.svh"
module spp_put_port #(
	parameter int        STREAM_LINK_COUNT          = 16,
	parameter bit        EXTENDED_STREAM_OPS_ENABLE = 1'b1,
	parameter logic [1:0] MEMORY_MGMT_LEVEL         = 2'h0,
	parameter bit        USER_STREAM_ACCESS_ALLOW   = 1'b0,
	parameter logic [1:0] AREA_TUNING_LEVEL         = 2'h0
) (
	// Clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         resetn,
	// Pipeline request
	input  wire logic                         instrValid,
	input  wire logic [31:0]                  instrWord,
	input  wire logic [`SPP_DATA_W-1:0]       srcRegData,
	input  wire logic                         userModeFlag,
	input  wire logic                         irqPending,
	// Pipeline answer
	output logic                              putDone,
	output logic                              pipeStall,
	output logic                              carryWrite,
	output logic                              carryFlag,
	output logic                              privException,
	output logic [4:0]                        exceptionCauseField,
	output logic                              illegalInstr,
	output logic                              irqBlock,
	output logic                              irqTake,
	// Outgoing stream links
	output logic [`SPP_NUM_LINKS-1:0]         m_axis_tvalid,
	output logic [`SPP_NUM_LINKS*`SPP_DATA_W-1:0] m_axis_tdata,
	output logic [`SPP_NUM_LINKS-1:0]         m_axis_tlast,
	input  wire logic [`SPP_NUM_LINKS-1:0]    m_axis_tready
);
	spp_pkg::spp_state_e stateReg;
	logic [`SPP_LINK_W-1:0] linkSel;
	logic [`SPP_LINK_W-1:0] curLink_reg;
	logic [1:0]             latCnt_reg;
	logic                   curN_reg, curT_reg, curA_reg;
	logic modN, modC, modT, modA, isPut, extOk, privFail, linkRdy;
	logic [1:0] latCycles;

	function automatic logic decodePut(input logic [31:0] w);
		decodePut = (w[`SPP_OPC_HI:`SPP_OPC_LO] == `SPP_OPC_PUT) &&
			w[`SPP_PUT_SEL_BIT];
	endfunction : decodePut

	assign modN = instrWord[`SPP_MOD_N_BIT];
	assign modC = instrWord[`SPP_MOD_C_BIT];
	assign modT = instrWord[`SPP_MOD_T_BIT];
	assign modA = instrWord[`SPP_MOD_A_BIT];
	assign isPut = (STREAM_LINK_COUNT > 0) && decodePut(instrWord);
	assign extOk = EXTENDED_STREAM_OPS_ENABLE || !(modT || modA);
	assign privFail = (MEMORY_MGMT_LEVEL != 2'h0) && !USER_STREAM_ACCESS_ALLOW
		&& userModeFlag;
	assign latCycles = (AREA_TUNING_LEVEL == 2'h1) ? `SPP_LAT_AREA
		: `SPP_LAT_FAST;
	assign linkRdy = m_axis_tready[curLink_reg];

	spp_link_sel #(
		.LINK_COUNT     (STREAM_LINK_COUNT)
	) u_link_sel (
		.linkIndexField (instrWord[`SPP_LINK_HI:`SPP_LINK_LO]),
		.linkSel        (linkSel)
	);

	// Sequencer and link drive
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			stateReg            <= spp_pkg::SPP_IDLE;
			curLink_reg         <= '0;
			latCnt_reg          <= '0;
			curN_reg            <= 1'b0;
			curT_reg            <= 1'b0;
			curA_reg            <= 1'b0;
			putDone             <= 1'b0;
			pipeStall           <= 1'b0;
			carryWrite          <= 1'b0;
			carryFlag           <= 1'b0;
			privException       <= 1'b0;
			exceptionCauseField <= '0;
			illegalInstr        <= 1'b0;
			irqBlock            <= 1'b0;
			irqTake             <= 1'b0;
			m_axis_tvalid       <= '0;
			m_axis_tdata        <= '0;
			m_axis_tlast        <= '0;
		end else begin
			putDone       <= 1'b0;
			carryWrite    <= 1'b0;
			privException <= 1'b0;
			illegalInstr  <= 1'b0;
			irqTake       <= 1'b0;
			case (stateReg)
				spp_pkg::SPP_IDLE: begin
					m_axis_tvalid <= '0;
					if (instrValid && isPut && !extOk) begin
						illegalInstr <= 1'b1;
						putDone      <= 1'b1;
						stateReg     <= spp_pkg::SPP_BUSY;
					end else if (instrValid && isPut && privFail) begin
						privException       <= 1'b1;
						exceptionCauseField <= `SPP_EC_PRIV;
						putDone             <= 1'b1;
						stateReg            <= spp_pkg::SPP_BUSY;
					end else if (instrValid && isPut) begin
						curLink_reg <= linkSel;
						curN_reg    <= modN;
						curT_reg    <= modT;
						curA_reg    <= modA;
						latCnt_reg  <= latCycles;
						m_axis_tdata[linkSel*`SPP_DATA_W +: `SPP_DATA_W]
							<= srcRegData;
						m_axis_tlast[linkSel] <= modC;
						m_axis_tvalid[linkSel] <= !modT
							&& (latCycles == `SPP_LAT_FAST);
						pipeStall   <= 1'b1;
						stateReg    <= spp_pkg::SPP_WAIT;
					end
				end
				spp_pkg::SPP_WAIT: begin
					if (latCnt_reg > 2'h1) begin
						latCnt_reg <= latCnt_reg - 2'h1;
						if (latCnt_reg == 2'h2) begin
							m_axis_tvalid[curLink_reg] <= !curT_reg;
						end
					end else if (curN_reg) begin
						m_axis_tvalid[curLink_reg] <= 1'b0;
						carryWrite <= 1'b1;
						carryFlag  <= !linkRdy;
						putDone    <= 1'b1;
						pipeStall  <= 1'b0;
						irqBlock   <= curA_reg;
						stateReg   <= spp_pkg::SPP_BUSY;
					end else if (linkRdy) begin
						m_axis_tvalid[curLink_reg] <= 1'b0;
						putDone   <= 1'b1;
						pipeStall <= 1'b0;
						irqBlock  <= curA_reg;
						stateReg  <= spp_pkg::SPP_BUSY;
					end else if (irqPending && EXTENDED_STREAM_OPS_ENABLE
						&& !curA_reg && !irqBlock) begin
						irqTake    <= 1'b1;
						m_axis_tvalid[curLink_reg] <= 1'b0;
						pipeStall  <= 1'b0;
						stateReg   <= spp_pkg::SPP_BUSY;
					end
				end
				spp_pkg::SPP_BUSY: begin
					m_axis_tvalid <= '0;
					if (!instrValid) begin
						stateReg <= spp_pkg::SPP_IDLE;
					end
				end
				default: stateReg <= spp_pkg::SPP_IDLE;
			endcase
			if (instrValid && !isPut && stateReg == spp_pkg::SPP_IDLE) begin
				irqBlock <= 1'b0;
			end
		end
	end
endmodule : spp_put_port

/* test/spp_sink_model.sv */
// Stream sink in place of the consuming logic
// Assumes the bench sets holdOff per link for a full store
`timescale 1ns/1ps
module spp_sink_model (
	// Links
	input  wire logic [15:0] m_axis_tvalid,
	input  wire logic [15:0] holdOff,
	output logic      [15:0] m_axis_tready
);
	// Ready low while full
	assign m_axis_tready = ~holdOff;
endmodule : spp_sink_model

/* test/spp_put_port_assertions.sv */
// Checker on the stream put port
// Assumes it is bound to spp_put_port
`timescale 1ns/1ps
module spp_put_port_chk (
	// Watched ports
	input wire logic         sys_clk, resetn, putDone, pipeStall, carryWrite,
	input wire logic         privException, irqBlock, irqTake,
	input wire logic [4:0]   exceptionCauseField,
	input wire logic [15:0]  m_axis_tvalid, m_axis_tlast, m_axis_tready,
	input wire logic [511:0] m_axis_tdata
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	cause_code_a: assert property (
		privException |=> exceptionCauseField == 5'h07) else $error("bad cause");
	priv_quiet_a: assert property (
		privException |-> m_axis_tvalid == 16'h0) else $error("link touched");
	done_unstall_a: assert property (
		putDone |-> !pipeStall) else $error("stall at done");
	word_hold_a: assert property (
		(|m_axis_tvalid) && $past(|m_axis_tvalid) |-> $stable(m_axis_tdata)
		&& $stable(m_axis_tlast)) else $error("word moved");
	valid_drop_a: assert property (
		$fell(|m_axis_tvalid) && !irqTake && !carryWrite |->
		$past(|m_axis_tready))
		else $error("valid dropped early");
	irq_stall_a: assert property (
		irqTake |-> $past(pipeStall) && !putDone) else $error("bad irq take");
	atomic_block_a: assert property (
		irqTake |-> !$past(irqBlock)) else $error("irq in atomic chain");
	done_pulse_a: assert property (
		putDone |=> !putDone) else $error("done too long");
	cover property (privException);
	cover property (irqTake);
	cover property (carryWrite);
endmodule : spp_put_port_chk
bind spp_put_port spp_put_port_chk spp_put_port_chk_inst (.*);

/* test/testbench.sv */
// Self-checking bench for the stream put port
// Assumes sink model and checker compile first
`timescale 1ns/1ps
module testbench;
	logic         sys_clk = 0, resetn = 0, instrValid = 0, userModeFlag = 0;
	logic         irqPending = 0, putDone, pipeStall, carryWrite, carryFlag;
	logic         privException, illegalInstr, irqBlock, irqTake;
	logic         f, c, sL, sC, sP, sI, sE;
	logic [4:0]   exceptionCauseField;
	logic [31:0]  instrWord = 0, srcRegData = 0, sD;
	logic [15:0]  m_axis_tvalid, m_axis_tlast, m_axis_tready, sV, holdOff = 0;
	logic [511:0] m_axis_tdata;
	logic [3:0]   m, lk, e;
	int           n_mismatch = 0, tests_run = 0, i, nCyc;
	// Rows: modifiers, link, full, expected link, expected carry
	logic [13:0]  rows [8] = '{{4'h0, 4'h3, 1'b0, 4'h3, 1'b0},
		{4'h4, 4'hd, 1'b0, 4'h0, 1'b0}, {4'h8, 4'h5, 1'b1, 4'h5, 1'b1},
		{4'hc, 4'hb, 1'b0, 4'hb, 1'b0}, {4'h2, 4'h1, 1'b0, 4'h1, 1'b0},
		{4'ha, 4'h2, 1'b1, 4'h2, 1'b1}, {4'h1, 4'h7, 1'b0, 4'h7, 1'b0},
		{4'hf, 4'hf, 1'b0, 4'h0, 1'b0}};
	always #5 sys_clk = ~sys_clk;
	spp_put_port #(.STREAM_LINK_COUNT(12), .MEMORY_MGMT_LEVEL(2'h1))
		spp_put_port_inst (.*);
	spp_sink_model spp_sink_model_inst (.*);
	task automatic chk(input logic [63:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report;
		if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task automatic stall(input logic [15:0] h, input int n);
		holdOff = h;
		fork
			begin
				repeat (n) @(negedge sys_clk);
				holdOff = 0;
			end
		join_none
	endtask : stall
	task automatic putOp(input logic [3:0] md, ln, ex, input logic [31:0] d);
		{sV, sC, sP, sI, sE} = 0;
		@(negedge sys_clk);
		instrValid = 1;
		instrWord = {6'h1b, 10'h0, 1'b1, md, 7'h0, ln};
		srcRegData = d;
		for (nCyc = 0; nCyc < 300; nCyc++) begin
			@(posedge sys_clk) #1;
			sV |= m_axis_tvalid;
			sP |= privException;
			sI |= irqTake;
			sE |= illegalInstr;
			if (carryWrite === 1'b1) sC = carryFlag;
			if ((putDone | irqTake) === 1'b1) break;
		end
		if (nCyc == 300) chk(0, 1);
		sD = m_axis_tdata[ex*32+:32];
		sL = m_axis_tlast[ex];
		@(negedge sys_clk);
		instrValid = 0;
	endtask : putOp
	initial begin
		repeat (20) @(negedge sys_clk);
		resetn = 1;
		for (i = 0; i < 8; i++) begin
			{m, lk, f, e, c} = rows[i];
			holdOff = {16{f}};
			repeat (4) @(negedge sys_clk);
			putOp(m, lk, e, 32'hc0de0000 + i);
			chk(sV, m[1] ? 16'h0 : 16'h1 << e);
			chk(nCyc, 1);
			chk(sE, 0);
			if (sV != 0) chk(sD, 32'hc0de0000 + i);
			if (sV != 0) chk(sL, m[2]);
			if (m[3]) chk(sC, c);
		end
		chk(irqBlock, 1);
		stall(16'h0010, 12);
		putOp(4'h0, 4'h4, 4'h4, 32'h5a5a0004);
		chk({nCyc >= 10, sV, sD}, {1'b1, 16'h0010, 32'h5a5a0004});
		irqPending = 1;
		stall(16'h0100, 15);
		putOp(4'h1, 4'h8, 4'h8, 32'h0);
		chk(sI, 0);
		userModeFlag = 1;
		putOp(4'h0, 4'h2, 4'h2, 32'h1);
		chk({sP, sV, exceptionCauseField}, {1'b1, 16'h0, 5'h07});
		userModeFlag = 0;
		resetn = 0;
		repeat (2) @(negedge sys_clk);
		resetn = 1;
		chk({irqBlock, pipeStall, putDone}, 0);
		stall(16'h0100, 20);
		putOp(4'h0, 4'h8, 4'h8, 32'h2);
		chk(sI, 1);
		final_report;
	end
	initial begin
		#100000;
		chk(0, 1);
		final_report;
	end
endmodule : testbench
